//--- core/cpwm_map.svh
`ifndef CPWM_MAP_SVH
`define CPWM_MAP_SVH
// mode field encodings
`define CPWM_MODE_OFF        4'h0
`define CPWM_MODE_TOG_CLR    4'h1
`define CPWM_MODE_TOG        4'h2
`define CPWM_MODE_SET        4'h8
`define CPWM_MODE_CLR        4'h9
`define CPWM_MODE_PULSE      4'ha
`define CPWM_MODE_PULSE_CLR  4'hb
// pwm modes have both top bits set
`define CPWM_PWM_BITS        2'h3
// prescale select codes (1:1, 1:4, 1:16, 1:64)
`define CPWM_PS_1            2'h0
`define CPWM_PS_4            2'h1
`define CPWM_PS_16           2'h2
`define CPWM_PS_64           2'h3
// last system clock phase of the four-clock instruction cycle
`define CPWM_QUARTER         2'h3
`define CPWM_PS_ZERO         6'h00
`define CPWM_DUTY_ZERO       10'h000
`define CPWM_CNT_ZERO        8'h00
`endif

//--- core/cpwm_pkg.sv
package cpwm_pkg;
    // output action chosen by the mode field
    typedef enum logic [2:0] {
        CPWM_ACT_NONE,
        CPWM_ACT_TOGGLE,
        CPWM_ACT_SET,
        CPWM_ACT_CLEAR,
        CPWM_ACT_PULSE
    } cpwm_act_t;
endpackage : cpwm_pkg

//--- core/cpwm_timebase.sv
`timescale 1ns/1ps
`include "cpwm_map.svh"
module cpwm_timebase
    import cpwm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       run_i,
    input  wire logic       sleep_i,
    input  wire logic [1:0] prescale_sel_i,
    input  wire logic [7:0] period_limit_i,
    output logic      [7:0] count_o,
    output logic      [1:0] sub_o,
    output logic            wrap_o
);
    typedef struct packed {
        logic [1:0] phase;
        logic [5:0] ps;
        logic [7:0] cnt;
        logic       wrap;
    } cpwm_tb_state_t;

    cpwm_tb_state_t s_q;
    cpwm_tb_state_t s_d;
    logic [5:0]     ps_top;
    logic           inc;

    // prescale last value for the chosen ratio
    always_comb
    begin
        unique case (prescale_sel_i)
            `CPWM_PS_1:  ps_top = 6'h00;
            `CPWM_PS_4:  ps_top = 6'h03;
            `CPWM_PS_16: ps_top = 6'h0f;
            `CPWM_PS_64: ps_top = 6'h3f;
        endcase
    end

    // prescaler advances once per four system clocks
    always_comb
    begin
        s_d      = s_q;
        // a wrap seen just before sleep is held so the unit can act on it after wake
        if (!sleep_i)
            s_d.wrap = 1'b0;
        inc      = 1'b0;
        if (run_i && !sleep_i)
        begin
            s_d.phase = s_q.phase + 2'h1;
            if (s_q.phase == `CPWM_QUARTER)
            begin
                s_d.ps = (s_q.ps == ps_top) ? `CPWM_PS_ZERO : s_q.ps + 6'h01;
                inc    = (s_q.ps == ps_top);
            end
            // period from limit plus one, no postscale
            if (inc)
            begin
                if (s_q.cnt == period_limit_i)
                begin
                    s_d.cnt  = `CPWM_CNT_ZERO;
                    s_d.wrap = 1'b1;
                end
                else
                    s_d.cnt = s_q.cnt + 8'h01;
            end
        end
        else if (!run_i)
        begin
            s_d.phase = 2'h0;
            s_d.ps    = `CPWM_PS_ZERO;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // low two bits: clock phase at 1:1, else prescaler top bits
    assign count_o = s_q.cnt;
    assign sub_o   = (prescale_sel_i == `CPWM_PS_1) ? s_q.phase
                   : (prescale_sel_i == `CPWM_PS_4) ? s_q.ps[1:0]
                   : (prescale_sel_i == `CPWM_PS_16) ? s_q.ps[3:2] : s_q.ps[5:4];
    assign wrap_o  = s_q.wrap;
endmodule : cpwm_timebase

//--- core/cpwm_unit.sv
`timescale 1ns/1ps
`include "cpwm_map.svh"
module cpwm_unit
    import cpwm_pkg::*;
#(
    parameter int CMP_W = 16
)
(
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             unit_enable_i,
    input  wire logic [3:0]       mode_i,
    input  wire logic             value_alignment_select_i,
    input  wire logic [CMP_W-1:0] duty_compare_value_i,
    input  wire logic [CMP_W-1:0] compare_timer_i,
    input  wire logic             compare_timer_tick_i,
    input  wire logic [7:0]       period_limit_i,
    input  wire logic [1:0]       timer_prescale_select_i,
    input  wire logic             timer_run_enable_i,
    input  wire logic             sleep_i,
    input  wire logic             pin_direction_bit_i,
    input  wire logic             pin_in_i,
    output logic                  pin_out_o,
    output logic                  pin_oe_o,
    output logic                  unit_out_o,
    output logic                  unit_event_o,
    output logic                  compare_timer_clear_o,
    output logic                  timer_overflow_o,
    output logic [7:0]            period_timer_count_o,
    output logic [9:0]            duty_buffer_o
);
    typedef struct packed {
        logic       out;
        logic       pulse;
        logic       evt;
        logic       tclr;
        logic       ovf;
        logic       matched;
        logic [9:0] duty_buf;
        logic [1:0] pin_sync;
        logic       oe;
        logic       lvl;
    } cpwm_state_t;

    cpwm_state_t s_q;
    cpwm_state_t s_d;
    logic [7:0]  tb_cnt;
    logic [1:0]  tb_sub;
    logic        tb_wrap;
    logic [9:0]  duty_new;
    logic [9:0]  base;
    logic        pwm_mode;
    logic        cmp_hit;
    cpwm_act_t   act;

    // map mode code onto a compare action
    function automatic cpwm_act_t cpwm_decode(input logic [3:0] m);
        unique case (m)
            `CPWM_MODE_TOG_CLR, `CPWM_MODE_TOG:       return CPWM_ACT_TOGGLE;
            `CPWM_MODE_SET:                           return CPWM_ACT_SET;
            `CPWM_MODE_CLR:                           return CPWM_ACT_CLEAR;
            `CPWM_MODE_PULSE, `CPWM_MODE_PULSE_CLR:   return CPWM_ACT_PULSE;
            default:                                  return CPWM_ACT_NONE;
        endcase
    endfunction : cpwm_decode

    // true when the mode asks to clear the compare timer
    function automatic logic cpwm_clears(input logic [3:0] m);
        return (m == `CPWM_MODE_TOG_CLR) || (m == `CPWM_MODE_PULSE_CLR);
    endfunction : cpwm_clears

    cpwm_timebase u_timebase (
        .mclk_i         (mclk_i),
        .sys_rst_i      (sys_rst_i),
        .run_i          (timer_run_enable_i),
        .sleep_i        (sleep_i),
        .prescale_sel_i (timer_prescale_select_i),
        .period_limit_i (period_limit_i),
        .count_o        (tb_cnt),
        .sub_o          (tb_sub),
        .wrap_o         (tb_wrap)
    );

    // pick the ten duty bits by alignment
    assign duty_new = value_alignment_select_i ? duty_compare_value_i[15:6]
                                               : duty_compare_value_i[9:0];
    assign base     = {tb_cnt, tb_sub};
    assign pwm_mode = unit_enable_i && (mode_i[3:2] == `CPWM_PWM_BITS);
    assign act      = cpwm_decode(mode_i);
    // continuous sixteen-bit compare, acted on at a timer tick
    // compare tick comes from a synchronous timer
    assign cmp_hit  = unit_enable_i && !pwm_mode && (act != CPWM_ACT_NONE)
                      && compare_timer_tick_i && (compare_timer_i == duty_compare_value_i);

    // next state of the output latch and flags
    always_comb
    begin
        s_d          = s_q;
        s_d.evt      = 1'b0;
        s_d.tclr     = 1'b0;
        s_d.pulse    = 1'b0;
        s_d.ovf      = tb_wrap && !sleep_i; // one pulse per wrap, held wrap not repeated
        s_d.pin_sync = {s_q.pin_sync[0], pin_in_i};
        // pin driver follows direction bit, input after reset
        s_d.oe       = !pin_direction_bit_i;
        if (!unit_enable_i || mode_i == `CPWM_MODE_OFF)
        begin
            // disabling or zero mode forces latch low
            s_d.out     = 1'b0;
            s_d.matched = 1'b0;
        end
        else if (pwm_mode)
        begin
            if (!sleep_i)
            begin
                if (tb_wrap)
                begin
                    s_d.duty_buf = duty_new;
                    s_d.out      = (duty_new != `CPWM_DUTY_ZERO);
                    s_d.evt      = 1'b1;
                end
                // clear on time base match, or at the wrap when the new duty is zero
                else if (base == s_q.duty_buf)
                    s_d.out = 1'b0;
            end
        end
        else
        begin
            // compare acts only while its timer ticks
            // perform compare action, raise event flag
            if (cmp_hit)
            begin
                s_d.evt  = 1'b1;
                s_d.tclr = cpwm_clears(mode_i);
                unique case (act)
                    CPWM_ACT_TOGGLE: s_d.out = !s_q.out;
                    CPWM_ACT_SET:    s_d.out = 1'b1;
                    CPWM_ACT_CLEAR:  s_d.out = 1'b0;
                    CPWM_ACT_PULSE:  s_d.pulse = 1'b1;
                    CPWM_ACT_NONE:   s_d.out = s_q.out;
                endcase
            end
        end
        // registered output level so the ports come straight from a flop
        s_d.lvl = s_d.out | s_d.pulse;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // unit output shared with peripherals and pin
    assign unit_out_o            = s_q.lvl;
    assign pin_out_o             = s_q.lvl;
    assign pin_oe_o              = s_q.oe;
    assign unit_event_o          = s_q.evt;
    assign compare_timer_clear_o = s_q.tclr;
    assign timer_overflow_o      = s_q.ovf;
    assign period_timer_count_o  = tb_cnt;
    assign duty_buffer_o         = s_q.duty_buf;
endmodule : cpwm_unit

//--- tb/cpwm_load.sv
`timescale 1ns/1ps
module cpwm_load
(
    input  wire logic pin_out_i,
    input  wire logic pin_oe_i,
    output logic      level_o
);
    // pull-down on the load holds the line low while the pin is released
    assign level_o = pin_oe_i ? pin_out_i : 1'b0;
endmodule : cpwm_load

//--- tb/cpwm_unit_properties.sv
`timescale 1ns/1ps
module cpwm_chk
    import cpwm_pkg::*;
#(
    parameter int CMP_W = 16
)
(
    input wire logic             mclk_i,
    input wire logic             sys_rst_i,
    input wire logic             unit_enable_i,
    input wire logic [3:0]       mode_i,
    input wire logic [CMP_W-1:0] duty_compare_value_i,
    input wire logic [CMP_W-1:0] compare_timer_i,
    input wire logic             compare_timer_tick_i,
    input wire logic [7:0]       period_limit_i,
    input wire logic             sleep_i,
    input wire logic             pin_direction_bit_i,
    input wire logic             pin_out_o,
    input wire logic             pin_oe_o,
    input wire logic             unit_out_o,
    input wire logic             unit_event_o,
    input wire logic             compare_timer_clear_o,
    input wire logic [7:0]       period_timer_count_o,
    input wire logic [9:0]       duty_buffer_o
);
    // compare hit and pwm mode decode
    wire logic hit = unit_enable_i && compare_timer_tick_i && compare_timer_i == duty_compare_value_i;
    wire logic pwm = mode_i[3:2] == 2'h3;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    chk_out_mirror: assert property (unit_out_o == pin_out_o) else $error("mirror");
    chk_oe_follow: assert property (pin_oe_o == !$past(pin_direction_bit_i)) else $error("oe");
    chk_off_low: assert property ((!unit_enable_i || mode_i == 4'h0) |=> !unit_out_o) else $error("off");
    chk_sleep_hold: assert property (sleep_i |=> $stable(period_timer_count_o) && $stable(unit_out_o)
        && $stable(duty_buffer_o)) else $error("sleep");
    chk_count_step: assert property ($changed(period_timer_count_o) |-> period_timer_count_o == 8'h00
        || period_timer_count_o == $past(period_timer_count_o) + 8'h01) else $error("step");
    chk_wrap_limit: assert property (($changed(period_timer_count_o) && period_timer_count_o == 8'h00)
        |-> $past(period_timer_count_o) == $past(period_limit_i)) else $error("wrap");
    chk_buf_at_wrap: assert property ($changed(duty_buffer_o) |-> period_timer_count_o == 8'h00) else $error("buf");
    chk_zero_duty: assert property ((pwm && duty_buffer_o == 10'h000) |-> !unit_out_o) else $error("zero");
    chk_cmp_set: assert property ((hit && mode_i == 4'h8) |=> unit_out_o && unit_event_o) else $error("set");
    chk_cmp_clr: assert property ((hit && mode_i == 4'h9) |=> !unit_out_o && unit_event_o) else $error("clr");
    chk_cmp_tog: assert property ((hit && (mode_i == 4'h1 || mode_i == 4'h2))
        |=> unit_out_o != $past(unit_out_o)) else $error("tog");
    chk_pulse_one: assert property ((hit && mode_i[3:1] == 3'h5) |=> unit_out_o ##1 !unit_out_o) else $error("pulse");
    chk_tmr_clear: assert property ((hit && (mode_i == 4'h1 || mode_i == 4'hb)) |=> compare_timer_clear_o)
        else $error("tclr");
    cover property (hit && mode_i == 4'ha);
    cover property (pwm && period_timer_count_o == period_limit_i);
    cover property (pwm && sleep_i);
endmodule : cpwm_chk
bind cpwm_unit cpwm_chk #(.CMP_W(CMP_W)) i_cpwm_chk (.mclk_i, .sys_rst_i, .unit_enable_i, .mode_i,
    .duty_compare_value_i, .compare_timer_i, .compare_timer_tick_i, .period_limit_i, .sleep_i,
    .pin_direction_bit_i, .pin_out_o, .pin_oe_o, .unit_out_o, .unit_event_o, .compare_timer_clear_o,
    .period_timer_count_o, .duty_buffer_o);

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, align = 1'b0, tick = 1'b0;
    logic        run = 1'b0, slp = 1'b0, dir = 1'b1, level;
    logic [3:0]  mode = 4'h0;
    logic [15:0] dcv = 16'h0000, ctmr = 16'h0000, hi, snap;
    logic [7:0]  lim = 8'h00, cnt;
    logic [1:0]  ps = 2'h0;
    logic        pout, poe, uout, uevt, tclr, ovf;
    logic [9:0]  dbuf;
    int          errors = 0, checks_done = 0;
    // pwm table: value, alignment, prescale, limit, high clocks per 128
    logic [15:0] t_dcv [4] = '{16'h0006, 16'h0180, 16'h0008, 16'h0000};
    logic        t_al  [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic [1:0]  t_ps  [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
    logic [7:0]  t_lim [4] = '{8'h03, 8'h03, 8'h00, 8'h01};
    logic [15:0] t_hi  [4] = '{16'h0030, 16'h0030, 16'h0080, 16'h0000};
    // compare table: mode, expected output, expected timer clear
    logic [3:0]  t_md  [8] = '{4'h8, 4'h9, 4'h8, 4'h0, 4'h2, 4'h1, 4'ha, 4'hb};
    logic        t_o   [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic        t_c   [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    // 40 MHz clock
    always #12.5 clk = ~clk;
    cpwm_unit i_cpwm_unit (.mclk_i(clk), .sys_rst_i(rst), .unit_enable_i(en), .mode_i(mode),
        .value_alignment_select_i(align), .duty_compare_value_i(dcv), .compare_timer_i(ctmr),
        .compare_timer_tick_i(tick), .period_limit_i(lim), .timer_prescale_select_i(ps),
        .timer_run_enable_i(run), .sleep_i(slp), .pin_direction_bit_i(dir), .pin_in_i(level),
        .pin_out_o(pout), .pin_oe_o(poe), .unit_out_o(uout), .unit_event_o(uevt),
        .compare_timer_clear_o(tclr), .timer_overflow_o(ovf), .period_timer_count_o(cnt),
        .duty_buffer_o(dbuf));
    cpwm_load i_cpwm_load (.pin_out_i(pout), .pin_oe_i(poe), .level_o(level));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    // three-cycle reset with outputs checked while held
    task automatic do_reset;
        rst <= 1'b1;
        {en, mode, run, slp, dir, tick} <= {1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0};
        @(posedge clk) #1;
        chk({poe, uout, uevt, tclr, ovf, 3'h0, cnt}, 16'h0000);
        chk(dbuf, 16'h0000);
        @(posedge clk);
        @(posedge clk) rst <= 1'b0;
    endtask : do_reset
    // bounded wait for the period overflow pulse
    task automatic wait_ovf;
        for (int i = 0; i < 2000 && ovf !== 1'b1; i++)
            @(posedge clk) #1;
        if (ovf !== 1'b1)
        begin
            errors++;
            complete_run();
        end
    endtask : wait_ovf
    initial
    begin
        for (int k = 0; k < 4; k++)
        begin
            do_reset();
            // setup order: driver off, limit, mode, duty, timer, overflow, driver on
            @(posedge clk) lim <= t_lim[k];
            @(posedge clk) {en, mode} <= {1'b1, 4'hc};
            @(posedge clk) {align, dcv, ps} <= {t_al[k], t_dcv[k], t_ps[k]};
            // timer runs from the quarter-rate instruction tick
            @(posedge clk) run <= 1'b1;
            wait_ovf();
            @(posedge clk) dir <= 1'b0;
            repeat (128) @(posedge clk);
            hi = 16'h0000;
            repeat (128) @(posedge clk) #1 hi = hi + 16'(level);
            chk(hi, t_hi[k]);
            chk(dbuf, t_dcv[k] >> (t_al[k] ? 6 : 0));
            @(posedge clk) slp <= 1'b1;
            @(posedge clk) #1 snap = {uout, cnt};
            repeat (40) @(posedge clk);
            #1 chk({uout, cnt}, snap);
        end
        do_reset();
        @(posedge clk) en <= 1'b1;
        // tick stands for a synchronous timer clocked at half rate
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk) {mode, dcv, ctmr, tick} <= {t_md[k], 16'ha5c3, 16'ha5c3, 1'b1};
            @(posedge clk) tick <= 1'b0;
            #1 chk({uout, uevt, tclr}, {t_o[k], t_md[k] != 4'h0, t_c[k]});
        end
        complete_run();
    end
endmodule : tb_top
